/* hw/sxm_master.sv */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////////////////////////
module sxm_master
  import sxm_pkg::*;
(
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  input  wire logic                       tx_valid,
  output logic                            tx_ready,
  input  wire logic [sxm_pkg::DATA_W-1:0] tx_data,
  input  wire logic [2:0]                 tx_sel,
  input  wire logic [1:0]                 tx_div,
  input  wire logic                       tx_cpol,
  input  wire logic                       tx_cpha,
  input  wire logic                       idle_cpol,
  output logic                            rx_valid,
  output logic      [sxm_pkg::DATA_W-1:0] rx_data,
  output logic                            busy,
  output logic                            spi_clk,
  output logic                            spi_mosi,
  input  wire logic                       spi_miso,
  output logic                            chip_select_zero_n,
  output logic                            chip_select_one_n,
  output logic                            adc_read_strobe
);

  import sxm_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TAIL} sxm_state_t;

  sxm_req_t          fifo_out;
  logic              fifo_vld, fifo_rdy;
  logic              miso_s1_r, miso_s2_r;
  sxm_state_t        st_r, st_nxt;
  sxm_cfg_t          cfg_r, cfg_nxt;
  logic [DATA_W-1:0] sh_r, sh_nxt;
  logic [3:0]        tick_r, tick_nxt, half;
  logic [4:0]        edge_r, edge_nxt;
  logic              clk_r, clk_nxt, mosi_r, mosi_nxt;
  logic              cs0_r, cs0_nxt, cs1_r, cs1_nxt, adc_r, adc_nxt;
  logic              rxv_r, rxv_nxt;
  logic [DATA_W-1:0] rxd_r, rxd_nxt;
  logic              idle_r, idle_nxt;
  logic              smp_r, smp_nxt;
  logic              busy_r, busy_nxt;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Requests wait in the buffer; full buffer stalls the producer.
  sxm_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   ({tx_sel, tx_div, tx_cpol, tx_cpha, tx_data}),
    .out_valid (fifo_vld),
    .out_ready (fifo_rdy),
    .out_data  (fifo_out)
  );

  //////////////////////////////////////////////////////////////////////////////////////////////
  // The data input comes from a pin, so it is synchronised before use.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
    end else if (ce) begin
      miso_s1_r <= spi_miso;
      miso_s2_r <= miso_s1_r;
    end
  end

  // Half period of the serial clock for the chosen divisor.
  always_comb begin
    unique case (cfg_r.div)
      DIV_BY_4:  half = HALF_DIV_4;
      DIV_BY_8:  half = HALF_DIV_8;
      DIV_BY_16: half = HALF_DIV_16;
      DIV_BY_32: half = HALF_DIV_32;
    endcase
  end

  // Transfer sequencer: select, clock edges, bit shifting and release.
  always_comb begin
    st_nxt   = st_r;
    cfg_nxt  = cfg_r;
    sh_nxt   = sh_r;
    tick_nxt = tick_r;
    edge_nxt = edge_r;
    clk_nxt  = clk_r;
    mosi_nxt = mosi_r;
    cs0_nxt  = cs0_r;
    cs1_nxt  = cs1_r;
    adc_nxt  = adc_r;
    rxv_nxt  = 1'b0;
    rxd_nxt  = rxd_r;
    idle_nxt = idle_r;
    fifo_rdy = 1'b0;
    smp_nxt  = 1'b0;
    // The data bit is taken one cycle after its clock edge, so the two-flop
    // synchroniser has caught up even at the fastest divisor.
    if (smp_r) begin
      sh_nxt = {sh_r[DATA_W-2:0], miso_s2_r};
    end
    unique case (st_r)
      ST_IDLE: begin
        clk_nxt  = idle_cpol;
        idle_nxt = idle_cpol;
        cs0_nxt  = CS_IDLE;
        cs1_nxt  = CS_IDLE;
        adc_nxt  = 1'b0;
        if (fifo_vld) begin
          fifo_rdy = 1'b1;
          cfg_nxt  = fifo_out.cfg;
          sh_nxt   = fifo_out.data;
          cs0_nxt  = !(fifo_out.cfg.sel == SEL_EXT0);
          cs1_nxt  = !(fifo_out.cfg.sel == SEL_EXT1);
          adc_nxt  = (fifo_out.cfg.sel == SEL_ADC);
          clk_nxt  = fifo_out.cfg.cpol;
          mosi_nxt = fifo_out.data[DATA_W-1];
          tick_nxt = '0;
          edge_nxt = '0;
          st_nxt   = ST_LEAD;
        end
      end
      ST_LEAD: begin
        // One half period of select setup; the shift state waits another half period before the first edge.
        tick_nxt = tick_r + 4'h1;
        if (tick_r == half) begin
          tick_nxt = '0;
          st_nxt   = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        tick_nxt = tick_r + 4'h1;
        if (tick_r == half) begin
          tick_nxt = '0;
          clk_nxt  = !clk_r;
          edge_nxt = edge_r + 5'h01;
          // Even edges sample when phase is clear, odd edges otherwise.
          if (edge_r[0] == cfg_r.cpha) begin
            smp_nxt = 1'b1;
          end else if (!(cfg_r.cpha && edge_r == 5'h00)) begin
            mosi_nxt = sh_r[DATA_W-1];
          end
          if (edge_r == 5'(2*DATA_W-1)) begin
            st_nxt = ST_TAIL;
          end
        end
      end
      ST_TAIL: begin
        tick_nxt = tick_r + 4'h1;
        if (tick_r == half) begin
          rxv_nxt  = 1'b1;
          rxd_nxt  = sh_r;
          cs0_nxt  = CS_IDLE;
          cs1_nxt  = CS_IDLE;
          adc_nxt  = 1'b0;
          clk_nxt  = idle_r;
          st_nxt   = ST_IDLE;
        end
      end
    endcase
    busy_nxt = (st_nxt != ST_IDLE);
  end

  // Registers the sequencer state and every pin.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r   <= ST_IDLE;
      cfg_r  <= '0;
      sh_r   <= '0;
      tick_r <= '0;
      edge_r <= '0;
      clk_r  <= 1'b0;
      mosi_r <= 1'b0;
      cs0_r  <= CS_IDLE;
      cs1_r  <= CS_IDLE;
      adc_r  <= 1'b0;
      rxv_r  <= 1'b0;
      rxd_r  <= '0;
      idle_r <= 1'b0;
      smp_r  <= 1'b0;
      busy_r <= 1'b0;
    end else if (ce) begin
      st_r   <= st_nxt;
      cfg_r  <= cfg_nxt;
      sh_r   <= sh_nxt;
      tick_r <= tick_nxt;
      edge_r <= edge_nxt;
      clk_r  <= clk_nxt;
      mosi_r <= mosi_nxt;
      cs0_r  <= cs0_nxt;
      cs1_r  <= cs1_nxt;
      adc_r  <= adc_nxt;
      rxv_r  <= rxv_nxt;
      rxd_r  <= rxd_nxt;
      idle_r <= idle_nxt;
      smp_r  <= smp_nxt;
      busy_r <= busy_nxt;
    end
  end

  // Outputs come straight from flip-flops.
  assign spi_clk            = clk_r;
  assign spi_mosi           = mosi_r;
  assign chip_select_zero_n = cs0_r;
  assign chip_select_one_n  = cs1_r;
  assign adc_read_strobe    = adc_r;
  assign rx_valid           = rxv_r;
  assign rx_data            = rxd_r;
  assign busy               = busy_r;

endmodule : sxm_master

/* shared/sxm_pkg.sv */
package sxm_pkg;

  // Serial word width and buffer depth.
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FIFO_DEPTH = 8;

  // Source clock for the serial divider, in MHz; no logic in the design uses it.
  localparam int unsigned SRC_CLK_MHZ = 33;

  // Divisor select codes: divide by 4, 8, 16 or 32.
  localparam logic [1:0] DIV_BY_4  = 2'h0;
  localparam logic [1:0] DIV_BY_8  = 2'h1;
  localparam logic [1:0] DIV_BY_16 = 2'h2;
  localparam logic [1:0] DIV_BY_32 = 2'h3;

  // Half periods of the serial clock in source cycles, less one, for each divisor.
  localparam logic [3:0] HALF_DIV_4  = 4'h1;
  localparam logic [3:0] HALF_DIV_8  = 4'h3;
  localparam logic [3:0] HALF_DIV_16 = 4'h7;
  localparam logic [3:0] HALF_DIV_32 = 4'hF;

  // Slave select codes; device number 5 is the on-board converter.
  localparam logic [2:0] SEL_EXT0 = 3'h0;
  localparam logic [2:0] SEL_EXT1 = 3'h1;
  localparam logic [2:0] SEL_ADC  = 3'h5;

  // Reset and idle level of the two chip select pins.
  localparam logic CS_IDLE = 1'b1;

  // Transfer configuration that travels with each word.
  typedef struct packed {
    logic [2:0] sel;
    logic [1:0] div;
    logic       cpol;
    logic       cpha;
  } sxm_cfg_t;

  // Word and its configuration as held in the buffer.
  typedef struct packed {
    sxm_cfg_t          cfg;
    logic [DATA_W-1:0] data;
  } sxm_req_t;

  localparam int unsigned REQ_W = $bits(sxm_req_t);

endpackage : sxm_pkg

/* hw/sxm_fifo.sv */
`timescale 1ns/1ps
module sxm_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic [WIDTH-1:0] dout_r, dout_nxt;
  logic             vld_r, vld_nxt;
  logic             rdy_r, rdy_nxt;
  logic             push, pop, load;

  // Storage holds words behind a registered output stage.
  always_comb begin
    push     = in_valid && rdy_r;
    load     = (cnt_r != '0) && (!vld_r || out_ready);
    pop      = load;
    wp_nxt   = push ? wp_r + 1'b1 : wp_r;
    rp_nxt   = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt  = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    dout_nxt = load ? mem_r[rp_r] : dout_r;
    vld_nxt  = load ? 1'b1 : (out_ready ? 1'b0 : vld_r);
    // The output stage counts toward the depth, so at most DEPTH words are held.
    rdy_nxt  = (cnt_nxt + (AW+1)'(vld_nxt)) != (AW+1)'(DEPTH);
  end

  // Registers the pointers, count and output word.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wp_r   <= '0;
      rp_r   <= '0;
      cnt_r  <= '0;
      vld_r  <= 1'b0;
      dout_r <= '0;
      rdy_r  <= 1'b1;
    end else if (ce) begin
      wp_r   <= wp_nxt;
      rp_r   <= rp_nxt;
      cnt_r  <= cnt_nxt;
      vld_r  <= vld_nxt;
      dout_r <= dout_nxt;
      rdy_r  <= rdy_nxt;
      if (push) begin
        mem_r[wp_r] <= in_data;
      end
    end
  end

  assign in_ready  = rdy_r;
  assign out_valid = vld_r;
  assign out_data  = dout_r;

endmodule : sxm_fifo

/* tb/sxm_checker.sv */
`timescale 1ns/1ps
////////////////////////////////
module sxm_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic rx_valid,
  input wire logic busy,
  input wire logic spi_clk,
  input wire logic idle_cpol,
  input wire logic chip_select_zero_n,
  input wire logic chip_select_one_n,
  input wire logic adc_read_strobe
);
  logic       sel_act;
  logic       sel_q;
  logic [4:0] edges;
  logic [5:0] gap;
  logic       gap_ok;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // A frame is any select being active.
  assign sel_act = !chip_select_zero_n || !chip_select_one_n || adc_read_strobe;
  // The lead-in before the first edge lasts two half periods.
  assign gap_ok = (edges == 5'h00) ? (gap inside {6'h04, 6'h08, 6'h10, 6'h20}) :
                                     (gap inside {6'h02, 6'h04, 6'h08, 6'h10});
  // Counts clock edges in a frame and enabled cycles between edges.
  always_ff @(posedge sys_clk) begin
    sel_q <= sel_act;
    if (rst || !sel_act) edges <= 5'h00;
    else if (sel_q && $changed(spi_clk)) edges <= edges + 5'h01;
    if (rst || !sel_q || $changed(spi_clk)) gap <= 6'h01;
    else if (ce) gap <= gap + 6'h01;
  end
  // The word result follows the end of a frame closely.
  sequence rx_soon_s;
    ##[0:2] rx_valid;
  endsequence
  sel_onehot_a: assert property ($onehot0({!chip_select_zero_n, !chip_select_one_n, adc_read_strobe}))
    else $error("two selects active");
  idle_select_a: assert property (!busy |-> chip_select_zero_n && chip_select_one_n && !adc_read_strobe)
    else $error("select active while idle");
  clk_in_frame_a: assert property ($changed(spi_clk) && !sel_act && !sel_q
    |-> spi_clk == $past(idle_cpol))
    else $error("clock moved outside a frame");
  frame_edges_a: assert property ($fell(sel_act) |-> edges == 5'h10)
    else $error("frame edge count wrong");
  half_period_a: assert property ($changed(spi_clk) && sel_q && sel_act |-> gap_ok)
    else $error("clock half period wrong");
  frame_rx_a: assert property ($fell(sel_act) |-> rx_soon_s)
    else $error("no word after frame");
  idle_level_a: assert property ($fell(sel_act) |-> spi_clk == idle_cpol)
    else $error("clock not at idle level");
  rx_pulse_a: assert property (rx_valid && ce |=> !rx_valid)
    else $error("rx valid too long");
  freeze_a: assert property (!ce |=> $stable({spi_clk, chip_select_zero_n, chip_select_one_n}))
    else $error("pins moved while frozen");
endmodule : sxm_checker

bind sxm_master sxm_checker CHK (.sys_clk, .rst, .ce, .rx_valid, .busy, .spi_clk, .idle_cpol,
  .chip_select_zero_n, .chip_select_one_n, .adc_read_strobe);

/* tb/sxm_slave_model.sv */
`timescale 1ns/1ps
////////////////////////////////
module sxm_slave_model (
  input  wire logic       spi_clk,
  input  wire logic       spi_mosi,
  input  wire logic       cs_n,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic      [7:0] rx_byte
);
  int   k = 0;
  logic lead = 1'b0;
  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
  end
  // A frame starts at the select; phase 0 shows its first bit at once.
  always @(negedge cs_n) begin
    k = 0;
    lead = 1'b0;
    if (!cpha) miso = tx_byte[7];
  end
  // Released output shows the inverse of its last bit.
  always @(posedge cs_n) miso = ~miso;
  // The clock is only read; samples on one edge, shifts on the other.
  always @(spi_clk) begin
    if (!cs_n && (spi_clk !== cpol || lead)) begin
      lead = (spi_clk !== cpol);
      if (lead ^ cpha) rx_byte = {rx_byte[6:0], spi_mosi};
      else begin
        if (!cpha) k = k + 1;
        if (k < 8) miso = tx_byte[7 - k];
        if (cpha) k = k + 1;
      end
    end
  end
endmodule : sxm_slave_model

/* tb/tb_top.sv */
`timescale 1ns/1ps
////////////////////////////////
module tb_top;
  import sxm_pkg::*;
  typedef struct packed {
    logic [2:0] sel;
    logic [1:0] div;
    logic       cpol;
    logic       cpha;
    logic [7:0] mo;
    logic [7:0] so;
    logic [2:0] seen;
    logic [4:0] gap;
  } sxm_row_t;
  // Each mode and divisor once, every select (EXT0 twice), with the expected selects and half period.
  localparam sxm_row_t ROWS [4] = '{
    '{SEL_EXT0, DIV_BY_4,  1'b0, 1'b0, 8'hA5, 8'h3C, 3'h1, 5'h02},
    '{SEL_EXT1, DIV_BY_8,  1'b0, 1'b1, 8'h81, 8'h7E, 3'h2, 5'h04},
    '{SEL_ADC,  DIV_BY_16, 1'b1, 1'b0, 8'h5A, 8'hC3, 3'h4, 5'h08},
    '{SEL_EXT0, DIV_BY_32, 1'b1, 1'b1, 8'h01, 8'h80, 3'h1, 5'h10}};
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       ce = 1'b1;
  logic       tx_valid = 1'b0;
  logic       tx_cpol = 1'b0;
  logic       tx_cpha = 1'b0;
  logic       idle_cpol = 1'b0;
  logic       clk_q = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] slv_tx = 8'h00;
  logic [2:0] tx_sel = 3'h0;
  logic [1:0] tx_div = 2'h0;
  logic [2:0] seen = 3'h0;
  logic [4:0] gap = 5'h00;
  logic [4:0] last_gap = 5'h00;
  logic       tx_ready, rx_valid, busy, spi_clk, spi_mosi, spi_miso, sel_n;
  logic       chip_select_zero_n, chip_select_one_n, adc_read_strobe;
  logic [7:0] rx_data, slv_rx;
  int         errors = 0;
  int         n_compared = 0;
  int         n;
  always #20 sys_clk = ~sys_clk;
  assign sel_n = chip_select_zero_n & chip_select_one_n & !adc_read_strobe;
  sxm_master DUT (.sys_clk, .rst, .ce, .tx_valid, .tx_ready, .tx_data, .tx_sel, .tx_div,
    .tx_cpol, .tx_cpha, .idle_cpol, .rx_valid, .rx_data, .busy, .spi_clk, .spi_mosi,
    .spi_miso, .chip_select_zero_n, .chip_select_one_n, .adc_read_strobe);
  sxm_slave_model SLV (.spi_clk, .spi_mosi, .cs_n(sel_n), .cpol(tx_cpol), .cpha(tx_cpha),
    .tx_byte(slv_tx), .miso(spi_miso), .rx_byte(slv_rx));
  // Records which selects fired and the spacing of the last two clock edges.
  always @(posedge sys_clk) begin
    seen <= tx_valid ? 3'h0 : seen | {adc_read_strobe, !chip_select_one_n, !chip_select_zero_n};
    clk_q <= spi_clk;
    if (spi_clk !== clk_q && !sel_n) begin
      last_gap <= gap;
      gap <= 5'h01;
    end else gap <= gap + 5'h01;
  end
  task automatic end_sim;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic send(input sxm_row_t r);
    tx_sel <= r.sel;
    tx_div <= r.div;
    tx_cpol <= r.cpol;
    tx_cpha <= r.cpha;
    tx_data <= r.mo;
    slv_tx <= r.so;
    tx_valid <= 1'b1;
    @(posedge sys_clk);
    while (tx_ready !== 1'b1) @(posedge sys_clk);
    tx_valid <= 1'b0;
  endtask : send
  task automatic wait_rx;
    for (int i = 0; i < 2000 && rx_valid !== 1'b1; i++) @(posedge sys_clk);
    chk("rx_valid", 8'h01, {7'h00, rx_valid});
  endtask : wait_rx
  task automatic chk_idle;
    chk("idle_pins", 8'h13, {1'b0, busy, rx_valid, tx_ready, adc_read_strobe, spi_clk,
      chip_select_one_n, chip_select_zero_n});
  endtask : chk_idle
  // A hang ends the run as a failure.
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    end_sim();
  end
  // Reset, the table of plain transfers, then buffer, stall and mid-run reset.
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    chk_idle();
    foreach (ROWS[i]) begin
      idle_cpol <= ROWS[i].cpha;
      send(ROWS[i]);
      repeat (8) @(posedge sys_clk);
      wait_rx();
      chk("rx_data", ROWS[i].so, rx_data);
      chk("slave_rx", ROWS[i].mo, slv_rx);
      chk("selects", {5'h00, ROWS[i].seen}, {5'h00, seen});
      chk("half_period", {3'h0, ROWS[i].gap}, {3'h0, last_gap});
      chk("idle_clk", {7'h00, idle_cpol}, {7'h00, spi_clk});
    end
    n = 0;
    tx_div <= DIV_BY_4;
    tx_valid <= 1'b1;
    @(posedge sys_clk);
    while (tx_ready === 1'b1 && n < 20) begin
      n++;
      @(posedge sys_clk);
    end
    tx_valid <= 1'b0;
    // The buffer holds its depth in words and one more is already on the link.
    chk("taken", 8'(FIFO_DEPTH + 1), 8'(n));
    ce <= 1'b0;
    repeat (10) @(posedge sys_clk);
    ce <= 1'b1;
    repeat (n) begin
      wait_rx();
      @(posedge sys_clk);
    end
    chk("drained", 8'h01, {7'h00, tx_ready});
    send(ROWS[0]);
    repeat (20) @(posedge sys_clk);
    idle_cpol <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    chk_idle();
    repeat (40) @(posedge sys_clk);
    end_sim();
  end
endmodule : tb_top
